/* File: dual_timer_pkg.sv */
// package for the dual timer block: modes, widths, reset values
// assumes a single 200 MHz clock domain and synchronous active-high reset
package dual_timer_pkg;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int CNT_WIDTH = 8;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic FLOP_RESET = 1'b0;

  // ---------------------------------------------------------------
  // mode encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    T1_TIMER = 2'h0,
    T1_COUNTER = 2'h1,
    T1_CAPTURE = 2'h2
  } t1_mode_type;

  typedef enum logic [1:0] {
    T3_TIMER = 2'h0,
    T3_COUNTER = 2'h1,
    T3_DIVIDER = 2'h2,
    T3_PWM = 2'h3
  } t3_mode_type;

  // capture arm state, one-hot
  typedef enum logic [1:0] {
    CAP_ARMED = 2'b01,
    CAP_HALTED = 2'b10
  } cap_state_type;

  // software control for counter 1
  typedef struct packed {
    t1_mode_type mode;
    logic edgeSelect;
    logic enable;
  } t1_ctrl_type;

  // software control for counter 3
  typedef struct packed {
    t3_mode_type mode;
    logic runBit;
  } t3_ctrl_type;

endpackage : dual_timer_pkg

/* File: dual_timer_capture_pwm.sv */
// dual 8-bit timer/counter with capture, divider output and pwm
// assumes all inputs synchronous to clk; pins pre-synchronised outside
`timescale 1ns/1ps

module dual_timer_capture_pwm #(
  parameter int WIDTH = dual_timer_pkg::CNT_WIDTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire dual_timer_pkg::t1_ctrl_type t1Ctrl,
  input wire logic t1SnapshotRequestSet,
  input wire logic t1ExtInput,
  input wire logic [WIDTH-1:0] t1MatchWrData,
  input wire logic t1MatchWrEn,
  input wire logic t1MatchRdStrobe,
  output logic [WIDTH-1:0] t1MatchCaptureA,
  output logic [WIDTH-1:0] t1SnapshotB,
  output logic t1SnapshotRequest,
  output logic [WIDTH-1:0] t1Count,
  output logic t1Irq,
  output logic t1OverflowIrq,
  input wire dual_timer_pkg::t3_ctrl_type t3Ctrl,
  input wire logic t3ExtInput,
  input wire logic [WIDTH-1:0] t3CompareWrData,
  input wire logic t3CompareWrEn,
  input wire logic t3FlopWrData,
  input wire logic t3FlopWrEn,
  output logic [WIDTH-1:0] t3CompareActive,
  output logic [WIDTH-1:0] t3Count,
  output logic t3Irq,
  output logic dividerOutput_n,
  output logic pwmOutput_n
);

  // ---------------------------------------------------------------
  // counter 1 state
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] cnt1_reg, cnt1_next;
  logic [WIDTH-1:0] regA_reg, regA_next;
  logic [WIDTH-1:0] regB_reg, regB_next;
  logic snapReq_reg, snapReq_next;
  logic ext1Prev_reg, ext1Prev_next;
  logic irq1_reg, irq1_next;
  logic ovf1_reg, ovf1_next;
  dual_timer_pkg::cap_state_type cap_reg, cap_next;
  logic ext1Rise, ext1Fall, activeEdge, oppEdge;
  logic run1;

  assign ext1Rise = t1ExtInput && !ext1Prev_reg;
  assign ext1Fall = !t1ExtInput && ext1Prev_reg;
  assign activeEdge = t1Ctrl.edgeSelect ? ext1Fall : ext1Rise;
  assign oppEdge = t1Ctrl.edgeSelect ? ext1Rise : ext1Fall;
  assign run1 = t1Ctrl.enable;

  always_comb begin
    cnt1_next = cnt1_reg;
    regA_next = regA_reg;
    regB_next = regB_reg;
    snapReq_next = snapReq_reg;
    ext1Prev_next = t1ExtInput;
    irq1_next = 1'b0;
    ovf1_next = 1'b0;
    cap_next = cap_reg;
    if (t1MatchWrEn) begin
      regA_next = t1MatchWrData;
    end
    if (t1MatchRdStrobe) begin
      cap_next = dual_timer_pkg::CAP_ARMED;
    end
    if (t1SnapshotRequestSet) begin
      snapReq_next = 1'b1;
    end
    if (run1) begin
      unique case (t1Ctrl.mode)
        dual_timer_pkg::T1_TIMER, dual_timer_pkg::T1_COUNTER: begin
          if (t1Ctrl.mode == dual_timer_pkg::T1_TIMER || activeEdge) begin
            if (cnt1_reg == regA_reg) begin
              cnt1_next = '0;
              irq1_next = 1'b1;
            end else begin
              cnt1_next = WIDTH'(cnt1_reg + 1'b1);
            end
          end
          if (snapReq_reg) begin
            regB_next = cnt1_reg;
            snapReq_next = 1'b0;
          end
        end
        dual_timer_pkg::T1_CAPTURE: begin
          cnt1_next = WIDTH'(cnt1_reg + 1'b1);
          snapReq_next = 1'b0;
          if (cap_reg == dual_timer_pkg::CAP_ARMED && !t1MatchRdStrobe) begin
            if (activeEdge) begin
              regA_next = cnt1_reg;
              cnt1_next = '0;
              irq1_next = 1'b1;
              cap_next = dual_timer_pkg::CAP_HALTED;
            end else if (cnt1_reg == dual_timer_pkg::ALL_ONES) begin
              regA_next = dual_timer_pkg::ALL_ONES;
              ovf1_next = 1'b1;
              cap_next = dual_timer_pkg::CAP_HALTED;
            end
          end
          if (oppEdge) begin
            regB_next = cnt1_reg;
          end
        end
        default: begin
          cnt1_next = cnt1_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt1_reg <= dual_timer_pkg::CNT_RESET;
      regA_reg <= dual_timer_pkg::CNT_RESET;
      regB_reg <= dual_timer_pkg::CNT_RESET;
      snapReq_reg <= 1'b0;
      ext1Prev_reg <= 1'b0;
      irq1_reg <= 1'b0;
      ovf1_reg <= 1'b0;
      cap_reg <= dual_timer_pkg::CAP_ARMED;
    end else begin
      cnt1_reg <= cnt1_next;
      regA_reg <= regA_next;
      regB_reg <= regB_next;
      snapReq_reg <= snapReq_next;
      ext1Prev_reg <= ext1Prev_next;
      irq1_reg <= irq1_next;
      ovf1_reg <= ovf1_next;
      cap_reg <= cap_next;
    end
  end

  assign t1MatchCaptureA = regA_reg;
  assign t1SnapshotB = regB_reg;
  assign t1SnapshotRequest = snapReq_reg;
  assign t1Count = cnt1_reg;
  assign t1Irq = irq1_reg;
  assign t1OverflowIrq = ovf1_reg;

  // ---------------------------------------------------------------
  // counter 3 state
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] cnt3_reg, cnt3_next;
  logic [WIDTH-1:0] cmpLoad_reg, cmpLoad_next;
  logic [WIDTH-1:0] cmpAct_reg, cmpAct_next;
  logic flop_reg, flop_next;
  logic ext3Prev_reg, ext3Prev_next;
  logic run3Prev_reg, run3Prev_next;
  logic irq3_reg, irq3_next;
  logic ext3Rise, runStart, match3, ovf3;

  assign ext3Rise = t3ExtInput && !ext3Prev_reg;
  assign runStart = t3Ctrl.runBit && !run3Prev_reg;
  assign match3 = cnt3_reg == cmpAct_reg;
  assign ovf3 = cnt3_reg == dual_timer_pkg::ALL_ONES;

  always_comb begin
    cnt3_next = cnt3_reg;
    cmpLoad_next = cmpLoad_reg;
    cmpAct_next = cmpAct_reg;
    flop_next = flop_reg;
    ext3Prev_next = t3ExtInput;
    run3Prev_next = t3Ctrl.runBit;
    irq3_next = 1'b0;
    if (t3CompareWrEn) begin
      cmpLoad_next = t3CompareWrData;
    end
    if (t3FlopWrEn) begin
      flop_next = t3FlopWrData;
    end
    if (runStart) begin
      cmpAct_next = cmpLoad_reg;
      cnt3_next = '0;
    end else if (t3Ctrl.runBit) begin
      unique case (t3Ctrl.mode)
        dual_timer_pkg::T3_TIMER, dual_timer_pkg::T3_COUNTER: begin
          cmpAct_next = cmpLoad_reg;
          if (t3Ctrl.mode == dual_timer_pkg::T3_TIMER || ext3Rise) begin
            if (match3) begin
              cnt3_next = '0;
              irq3_next = 1'b1;
            end else begin
              cnt3_next = WIDTH'(cnt3_reg + 1'b1);
            end
          end
        end
        dual_timer_pkg::T3_DIVIDER: begin
          cmpAct_next = cmpLoad_reg;
          if (match3) begin
            cnt3_next = '0;
            flop_next = !flop_reg;
            irq3_next = 1'b1;
          end else begin
            cnt3_next = WIDTH'(cnt3_reg + 1'b1);
          end
        end
        dual_timer_pkg::T3_PWM: begin
          if (ovf3) begin
            cnt3_next = '0;
            flop_next = !flop_reg;
            irq3_next = 1'b1;
            cmpAct_next = cmpLoad_reg;
          end else begin
            cnt3_next = WIDTH'(cnt3_reg + 1'b1);
            if (match3) begin
              flop_next = !flop_reg;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt3_reg <= dual_timer_pkg::CNT_RESET;
      cmpLoad_reg <= dual_timer_pkg::CNT_RESET;
      cmpAct_reg <= dual_timer_pkg::CNT_RESET;
      flop_reg <= dual_timer_pkg::FLOP_RESET;
      ext3Prev_reg <= 1'b0;
      run3Prev_reg <= 1'b0;
      irq3_reg <= 1'b0;
    end else begin
      cnt3_reg <= cnt3_next;
      cmpLoad_reg <= cmpLoad_next;
      cmpAct_reg <= cmpAct_next;
      flop_reg <= flop_next;
      ext3Prev_reg <= ext3Prev_next;
      run3Prev_reg <= run3Prev_next;
      irq3_reg <= irq3_next;
    end
  end

  assign t3CompareActive = cmpAct_reg;
  assign t3Count = cnt3_reg;
  assign t3Irq = irq3_reg;
  assign dividerOutput_n = (t3Ctrl.mode == dual_timer_pkg::T3_DIVIDER) ? !flop_reg : 1'b1;
  assign pwmOutput_n = (t3Ctrl.mode == dual_timer_pkg::T3_PWM) ? !flop_reg : 1'b1;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  match_clear_a: assert property (run1 && t1Ctrl.mode == dual_timer_pkg::T1_TIMER
    && cnt1_reg == regA_reg && !t1MatchWrEn |=> cnt1_reg == '0 && irq1_reg)
    else $error("counter 1 match did not clear");
  snap_clear_a: assert property (run1 && t1Ctrl.mode != dual_timer_pkg::T1_CAPTURE
    && snapReq_reg && !t1SnapshotRequestSet |=> !snapReq_reg && regB_reg == $past(cnt1_reg))
    else $error("snapshot not taken");
  cap_load_a: assert property (run1 && t1Ctrl.mode == dual_timer_pkg::T1_CAPTURE
    && cap_reg == dual_timer_pkg::CAP_ARMED && !t1MatchRdStrobe && activeEdge
    |=> regA_reg == $past(cnt1_reg) && cnt1_reg == '0 && irq1_reg)
    else $error("capture edge not handled");
  cap_halt_a: assert property ($past(run1 && t1Ctrl.mode == dual_timer_pkg::T1_CAPTURE)
    && (irq1_reg || ovf1_reg) |-> cap_reg == dual_timer_pkg::CAP_HALTED)
    else $error("capture not halted after event");
  cap_ovf_a: assert property (ovf1_reg |-> regA_reg == dual_timer_pkg::ALL_ONES)
    else $error("overflow did not load all ones");
  div_toggle_a: assert property (t3Ctrl.runBit && !runStart
    && t3Ctrl.mode == dual_timer_pkg::T3_DIVIDER && match3 && !t3FlopWrEn
    |=> flop_reg != $past(flop_reg) && cnt3_reg == '0 && irq3_reg)
    else $error("divider toggle missing");
  pwm_ovf_a: assert property (t3Ctrl.runBit && !runStart
    && t3Ctrl.mode == dual_timer_pkg::T3_PWM && ovf3 |=> irq3_reg && cnt3_reg == '0)
    else $error("pwm overflow irq missing");
  pwm_hold_a: assert property (t3Ctrl.mode == dual_timer_pkg::T3_PWM && !ovf3
    && !runStart |=> $stable(cmpAct_reg))
    else $error("pwm compare changed mid period");
  run_load_a: assert property (runStart |=> cmpAct_reg == $past(cmpLoad_reg))
    else $error("run start did not load compare");

  cap_seen_c: cover property (irq1_reg && t1Ctrl.mode == dual_timer_pkg::T1_CAPTURE);
  ovf_seen_c: cover property (ovf1_reg);
  pwm_seen_c: cover property (irq3_reg && t3Ctrl.mode == dual_timer_pkg::T3_PWM);

endmodule : dual_timer_capture_pwm

/* File: pulse_source.sv */
// partner model: external pulse source for both counter input pins
// assumes the design samples pins on rising clk; levels change 1 ns after it
`timescale 1ns/1ps
module pulse_source (
  input wire logic clk,
  output logic t1Pin,
  output logic t3Pin
);
  int cyc = 0;
  int riseAt = 0;
  int fallAt = 0;

  initial begin
    t1Pin = 1'b0;
    t3Pin = 1'b0;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  // single level step: one edge per call, so the edge kind is known
  task automatic drive(input bit sel, input logic lvl, input int hold);
    @(posedge clk);
    #1;
    if (sel) begin
      t3Pin = lvl;
    end else begin
      t1Pin = lvl;
      if (lvl) begin
        riseAt = cyc;
      end else begin
        fallAt = cyc;
      end
    end
    repeat (hold) @(posedge clk);
    #1;
  endtask : drive
endmodule : pulse_source

/* File: dual_timer_capture_pwm_tb.sv */
// testbench for the dual timer: pulse source partner plus event log and direct checks
// assumes 200 MHz clk, synchronous active-high rst, inputs driven 1 ns late
`timescale 1ns/1ps
module dual_timer_capture_pwm_tb;
  logic clk, rst, t1SnapshotRequestSet, t1MatchWrEn, t1MatchRdStrobe;
  logic t3CompareWrEn, t3FlopWrData, t3FlopWrEn, t1ExtInput, t3ExtInput;
  logic t1SnapshotRequest, t1Irq, t1OverflowIrq, t3Irq, dividerOutput_n, pwmOutput_n;
  logic [7:0] t1MatchWrData, t3CompareWrData, t1MatchCaptureA, t1SnapshotB;
  logic [7:0] t1Count, t3CompareActive, t3Count, keep;
  dual_timer_pkg::t1_ctrl_type t1Ctrl;
  dual_timer_pkg::t3_ctrl_type t3Ctrl;
  int fail_count = 0;
  int total_checks = 0;
  int q1[$], qOv[$], q3[$], qLow[$];
  logic qDiv[$];
  int lowCnt = 0;
  int a, c, n, r1;

  dual_timer_capture_pwm i_dut (.clk, .rst, .t1Ctrl, .t1SnapshotRequestSet, .t1ExtInput,
    .t1MatchWrData, .t1MatchWrEn, .t1MatchRdStrobe, .t1MatchCaptureA, .t1SnapshotB,
    .t1SnapshotRequest, .t1Count, .t1Irq, .t1OverflowIrq, .t3Ctrl, .t3ExtInput,
    .t3CompareWrData, .t3CompareWrEn, .t3FlopWrData, .t3FlopWrEn, .t3CompareActive,
    .t3Count, .t3Irq, .dividerOutput_n, .pwmOutput_n);
  pulse_source i_src (.clk, .t1Pin(t1ExtInput), .t3Pin(t3ExtInput));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // event log: interrupt times, divider level, pwm low time
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (t1Irq === 1'b1) q1.push_back(i_src.cyc);
    if (t1OverflowIrq === 1'b1) qOv.push_back(i_src.cyc);
    if (t3Irq === 1'b1) begin
      q3.push_back(i_src.cyc);
      qDiv.push_back(dividerOutput_n);
      qLow.push_back(lowCnt);
      lowCnt = 0;
    end
    if (pwmOutput_n === 1'b0) lowCnt++;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input string what, input int expd, input logic [15:0] seen,
                       input int tol);
    bit bad;
    bad = $isunknown(seen) || int'(seen) > expd + tol || int'(seen) < expd - tol;
    total_checks++;
    if (bad) begin
      fail_count++;
      $display("mismatch %s expected %0d seen %0d", what, expd, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic waitFor(input int which, input int k);
    int i;
    for (i = 0; i < 2000; i++) begin
      if ((which == 1 ? q1.size() : which == 2 ? qOv.size() : q3.size()) >= k) break;
      step(1);
    end
    if (i == 2000) begin
      fail_count++;
      $display("mismatch wait %0d expected %0d seen less", which, k);
      results();
    end
  endtask : waitFor

  task automatic wrT1(input int v);
    t1MatchWrData = 8'(v);
    t1MatchWrEn = 1'b1;
    step(1);
    t1MatchWrEn = 1'b0;
  endtask : wrT1

  task automatic wrT3(input int v);
    t3CompareWrData = 8'(v);
    t3CompareWrEn = 1'b1;
    step(1);
    t3CompareWrEn = 1'b0;
  endtask : wrT3

  task automatic readA();
    t1MatchRdStrobe = 1'b1;
    step(1);
    t1MatchRdStrobe = 1'b0;
  endtask : readA

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h4402959C));
    {rst, t1SnapshotRequestSet, t1MatchWrEn, t1MatchRdStrobe} = 4'h8;
    {t3CompareWrEn, t3FlopWrData, t3FlopWrEn, t1MatchWrData, t3CompareWrData} = '0;
    t1Ctrl = '0;
    t3Ctrl = '{dual_timer_pkg::T3_DIVIDER, 1'b0};
    step(20);
    rst = 1'b0;
    check("divider pin", 1, dividerOutput_n, 0);
    check("pwm pin", 1, pwmOutput_n, 0);
    a = 2 + $urandom_range(20);
    wrT1(a);
    t1Ctrl = '{dual_timer_pkg::T1_TIMER, 1'b0, 1'b1};
    waitFor(1, 3);
    check("t1 period", a + 1, 16'(q1[$] - q1[$-1]), 0);
    wrT1(200);
    c = t1Count;
    t1SnapshotRequestSet = 1'b1;
    step(1);
    t1SnapshotRequestSet = 1'b0;
    step(3);
    check("snap request", 0, t1SnapshotRequest, 0);
    check("snap value", c + 1, t1SnapshotB, 0);
    $display("test timer1 done");
    t1Ctrl = '{dual_timer_pkg::T1_COUNTER, 1'b1, 1'b1};
    step(2);
    c = t1Count;
    repeat (5) begin
      i_src.drive(0, 1'b1, 2);
      i_src.drive(0, 1'b0, 2);
    end
    check("falling count", c + 5, t1Count, 0);
    t1Ctrl = '{dual_timer_pkg::T1_CAPTURE, 1'b0, 1'b1};
    readA();
    n = q1.size();
    i_src.drive(0, 1'b1, 3);
    r1 = i_src.riseAt;
    readA();
    a = 5 + $urandom_range(40);
    i_src.drive(0, 1'b0, a);
    i_src.drive(0, 1'b1, 4);
    check("capture irqs", n + 2, 16'(q1.size()), 0);
    check("capture A", i_src.riseAt - r1 - 1, t1MatchCaptureA, 0);
    check("capture B", i_src.fallAt - r1 - 1, t1SnapshotB, 0);
    keep = t1MatchCaptureA;
    i_src.drive(0, 1'b0, 3);
    i_src.drive(0, 1'b1, 4);
    check("halted irqs", n + 2, 16'(q1.size()), 0);
    check("halted A", keep, t1MatchCaptureA, 0);
    readA();
    waitFor(2, 1);
    step(1);
    check("overflow A", 255, t1MatchCaptureA, 0);
    $display("test capture done");
    c = 2 + $urandom_range(30);
    wrT3(c);
    t3Ctrl = '{dual_timer_pkg::T3_TIMER, 1'b1};
    waitFor(3, 3);
    check("t3 period", c + 1, 16'(q3[$] - q3[$-1]), 0);
    t3Ctrl = '{dual_timer_pkg::T3_COUNTER, 1'b0};
    wrT3(3);
    t3Ctrl.runBit = 1'b1;
    step(2);
    n = q3.size();
    repeat (8) begin
      i_src.drive(1, 1'b1, 1);
      i_src.drive(1, 1'b0, 1);
    end
    check("t3 edge irqs", n + 2, 16'(q3.size()), 0);
    wrT3(c);
    t3Ctrl = '{dual_timer_pkg::T3_DIVIDER, 1'b1};
    waitFor(3, q3.size() + 3);
    check("divider period", c + 1, 16'(q3[$] - q3[$-1]), 0);
    check("divider toggle", 1, 16'(qDiv[$] ^ qDiv[$-1]), 0);
    t3Ctrl.runBit = 1'b0;
    for (int v = 1; v >= 0; v--) begin
      t3FlopWrData = v[0];
      t3FlopWrEn = 1'b1;
      step(1);
      t3FlopWrEn = 1'b0;
      step(1);
      check("flop write", 1 - v, dividerOutput_n, 0);
    end
    $display("test counter3 done");
    c = 20 + $urandom_range(200);
    wrT3(c);
    t3Ctrl = '{dual_timer_pkg::T3_PWM, 1'b0};
    step(1);
    t3Ctrl.runBit = 1'b1;
    step(2);
    check("first compare", c, t3CompareActive, 0);
    check("start count", 1, t3Count, 0);
    waitFor(3, q3.size() + 2);
    check("pwm period", 256, 16'(q3[$] - q3[$-1]), 0);
    check("pwm low time", 255 - c, 16'(qLow[$]), 0);
    a = 20 + $urandom_range(200);
    wrT3(a);
    step(2);
    check("held compare", c, t3CompareActive, 0);
    n = q3.size();
    waitFor(3, n + 1);
    step(2);
    check("new compare", a, t3CompareActive, 0);
    waitFor(3, n + 2);
    check("new low time", 255 - a, 16'(qLow[$]), 0);
    $display("test pwm done");
    results();
  end
endmodule : dual_timer_capture_pwm_tb
